/* shared/dps_pkg.sv */
// Shared constants and types for the potentiometer two-wire port
package dps_pkg;

   // ========================================================
   // Wiper and instruction byte
   localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
   localparam logic [7:0] WIPER_RST = WIPER_MIDSCALE;
   localparam int INSTR_MIDRST_BIT = 6;
   localparam int INSTR_SHDN_BIT = 5;

   // ========================================================
   // Bit counting inside a nine-pulse byte frame
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   // ========================================================
   // Timing of the generated clock
   localparam int CLK_PERIOD_NS = 50;
   localparam int SCL_HALF_NS = 5000;
   localparam int SCL_HALF_CYC =
      (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ========================================================
   // Controller register map (byte addresses)
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [31:0] CMD_RST = 32'h0000_0000;
   localparam int CMD_ADDR_LSB = 0;
   localparam int CMD_RW_BIT = 7;
   localparam int CMD_INSTR_LSB = 8;
   localparam int CMD_DATA_LSB = 16;
   localparam int CMD_CNT_LSB = 24;
   localparam int CMD_GO_BIT = 31;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_RDATA_LSB = 8;

   // ========================================================
   // State encodings
   typedef enum logic [4:0] {
      DV_IDLE = 5'h01,
      DV_RX   = 5'h02,
      DV_ACK  = 5'h04,
      DV_TX   = 5'h08,
      DV_MACK = 5'h10
   } dps_dev_st_t;

   typedef enum logic [2:0] {
      PH_ADDR  = 3'h1,
      PH_INSTR = 3'h2,
      PH_DATA  = 3'h4
   } dps_phase_t;

   typedef enum logic [6:0] {
      HS_IDLE  = 7'h01,
      HS_START = 7'h02,
      HS_BLO   = 7'h04,
      HS_BHI   = 7'h08,
      HS_STA   = 7'h10,
      HS_STB   = 7'h20,
      HS_STC   = 7'h40
   } dps_host_st_t;

endpackage

/* shared/dps_bus_if.sv */
// Two-wire bus joining the controller and the potentiometer port
`timescale 1ns/100ps
interface dps_bus_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // Open-drain wires with pull-up
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport master (
      output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
      input scl, sda
   );
   modport slave (
      output s_sda_o, s_sda_oe,
      input scl, sda
   );
endinterface

/* src/dps_cond_det.sv */
// Bus event detector: START, STOP and clock edges from sampled lines
`timescale 1ns/100ps
module dps_cond_det (
   input wire logic ref_clk_i,   // System clock
   input wire logic rst_n_i,     // Async reset, active low
   input wire logic ce_i,        // Clock enable
   input wire logic scl_i,       // Sampled clock line
   input wire logic sda_i,       // Sampled data line
   output logic start_o,         // START seen, pulse
   output logic stop_o,          // STOP seen, pulse
   output logic scl_rise_o,      // Clock rose, pulse
   output logic scl_fall_o       // Clock fell, pulse
);
   logic scl_q, scl_d;
   logic sda_q, sda_d;

   always_comb
   begin
      scl_d = scl_i;
      sda_d = sda_i;
      start_o = ce_i && scl_q && scl_i && sda_q && !sda_i;
      stop_o = ce_i && scl_q && scl_i && !sda_q && sda_i;
      scl_rise_o = ce_i && !scl_q && scl_i;
      scl_fall_o = ce_i && scl_q && !scl_i;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end
endmodule

/* src/dps_dev.sv */
// Two-wire slave port of a 256-position digital potentiometer
// Summary of operation
// - Slave port active while select pin high
// - Address: fixed prefix plus address-select pin
// - START (SDA falls, SCL high) begins transfer
// - Matched address acked; others stay released
// - R/W low writes, high reads
// - Write: instruction byte, MSB and low five ignored
// - Midscale bit overwrites wiper with midscale
// - Shutdown bit opens A, shorts wiper to B
// - Shutdown keeps wiper, accepts writes, reapplies
// - Bytes: eight bits MSB first plus ack
// - SDA changes only while SCL low
// - Read sends wiper right after address ack
// - STOP (SDA rises, SCL high) ends addressing
// - Master ends write with STOP
// - Master ends read with NACK then STOP
// - Further write bytes load wiper, same instruction
// - New instruction needs new write transfer
// - Acked read bytes repeat wiper value
// - Wiper register eight bits, read back
`timescale 1ns/100ps
module dps_dev
   import dps_pkg::*;
#(
   parameter logic [5:0] ADDR_PREFIX = 6'h2a // Arbitrary value
)
(
   input wire logic ref_clk_i,             // System clock
   input wire logic rst_n_i,               // Async reset, active low
   input wire logic ce_i,                  // Clock enable
   dps_bus_if.slave bus,                   // Two-wire bus
   input wire logic interface_select_pin_i, // High selects this port
   input wire logic address_select_pin_i,  // Low address bit
   output logic [7:0] wiper_code_o,        // Wiper register
   output logic terminal_a_open_o,         // Terminal A opened
   output logic wiper_b_short_o,           // Wiper shorted to B
   output logic addressed_o                // Transfer in progress
);
   logic start, stop, scl_rise, scl_fall;
   dps_dev_st_t st_q, st_d;
   dps_phase_t ph_q, ph_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] rx_q, rx_d;
   logic [7:0] tx_q, tx_d;
   logic rw_q, rw_d;
   logic nack_q, nack_d;
   logic midrst_q, midrst_d;
   logic shdn_q, shdn_d;
   logic [7:0] wiper_q, wiper_d;

   // ========================================================
   // Bus events
   dps_cond_det u_det (
      .ref_clk_i (ref_clk_i),
      .rst_n_i (rst_n_i),
      .ce_i (ce_i),
      .scl_i (bus.scl),
      .sda_i (bus.sda),
      .start_o (start),
      .stop_o (stop),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall)
   );

   // ========================================================
   // Protocol engine
   always_comb
   begin
      st_d = st_q;
      ph_d = ph_q;
      cnt_d = cnt_q;
      rx_d = rx_q;
      tx_d = tx_q;
      rw_d = rw_q;
      nack_d = nack_q;
      midrst_d = midrst_q;
      shdn_d = shdn_q;
      wiper_d = wiper_q;
      if (!interface_select_pin_i)
      begin
         st_d = DV_IDLE;
      end
      else if (stop)
      begin
         st_d = DV_IDLE;
      end
      else if (start)
      begin
         st_d = DV_RX;
         ph_d = PH_ADDR;
         cnt_d = 4'h0;
      end
      else
      begin
         case (st_q)
            DV_IDLE:
            begin
               cnt_d = 4'h0;
            end
            DV_RX:
            begin
               if (scl_rise && cnt_q != BIT_ACK)
               begin
                  rx_d = {rx_q[6:0], bus.sda};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (scl_fall && cnt_q == BIT_ACK)
               begin
                  st_d = DV_ACK;
                  case (ph_q)
                     PH_ADDR:
                     begin
                        if (rx_q[7:1] == {ADDR_PREFIX,
                                          address_select_pin_i})
                        begin
                           rw_d = rx_q[0];
                        end
                        else
                        begin
                           st_d = DV_IDLE;
                        end
                     end
                     PH_INSTR:
                     begin
                        midrst_d = rx_q[INSTR_MIDRST_BIT];
                        shdn_d = rx_q[INSTR_SHDN_BIT];
                        if (rx_q[INSTR_MIDRST_BIT])
                        begin
                           wiper_d = WIPER_MIDSCALE;
                        end
                     end
                     PH_DATA:
                     begin
                        // Midscale request held: data re-centres
                        wiper_d = midrst_q ? WIPER_MIDSCALE : rx_q;
                     end
                     default:
                     begin
                        st_d = DV_IDLE;
                     end
                  endcase
               end
            end
            DV_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_d = 4'h0;
                  if (rw_q)
                  begin
                     st_d = DV_TX;
                     tx_d = wiper_q;
                  end
                  else
                  begin
                     st_d = DV_RX;
                     ph_d = (ph_q == PH_ADDR) ? PH_INSTR : PH_DATA;
                  end
               end
            end
            DV_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_q == BIT_LAST)
                  begin
                     st_d = DV_MACK;
                  end
                  else
                  begin
                     tx_d = {tx_q[6:0], 1'b0};
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            DV_MACK:
            begin
               if (scl_rise)
               begin
                  nack_d = bus.sda;
               end
               else if (scl_fall)
               begin
                  if (nack_q)
                  begin
                     st_d = DV_IDLE;
                  end
                  else
                  begin
                     st_d = DV_TX;
                     tx_d = wiper_q;
                     cnt_d = 4'h0;
                  end
               end
            end
            default:
            begin
               st_d = DV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= DV_IDLE;
         ph_q <= PH_ADDR;
         cnt_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         midrst_q <= 1'b0;
         shdn_q <= 1'b0;
         wiper_q <= WIPER_RST;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         midrst_q <= midrst_d;
         shdn_q <= shdn_d;
         wiper_q <= wiper_d;
      end
   end

   // ========================================================
   // Pins and analog control
   always_comb
   begin
      bus.s_sda_o = 1'b0;
      bus.s_sda_oe = (st_q == DV_ACK) ||
                     (st_q == DV_TX && !tx_q[7]);
      wiper_code_o = wiper_q;
      terminal_a_open_o = shdn_q;
      wiper_b_short_o = shdn_q;
      addressed_o = (st_q != DV_IDLE);
   end
endmodule

/* src/dps_host.sv */
// Two-wire bus controller with a classic Wishbone register port
`timescale 1ns/100ps
module dps_host
   import dps_pkg::*;
#(
   parameter int HALF_CYC = SCL_HALF_CYC
)
(
   input wire logic ref_clk_i,      // System clock
   input wire logic rst_n_i,        // Async reset, active low
   input wire logic ce_i,           // Clock enable
   input wire logic wb_cyc_i,       // Bus cycle
   input wire logic wb_stb_i,       // Strobe
   input wire logic wb_we_i,        // Write enable
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o,    // Read data
   output logic wb_ack_o,           // Acknowledge
   dps_bus_if.master bus,           // Two-wire bus
   output logic busy_o              // Transfer running
);
   localparam logic [15:0] HALF_LOAD = 16'(HALF_CYC - 1);
   dps_host_st_t st_q, st_d;
   logic [31:0] cmd_q, cmd_d;
   logic [15:0] tmr_q, tmr_d;
   logic [4:0] bidx_q, bidx_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] rx_q, rx_d;
   logic nack_q, nack_d;
   logic scl_q, scl_d;
   logic sdal_q, sdal_d;
   logic ack_q, ack_d;
   logic [31:0] rd_q, rd_d;
   logic tick, go, sending, last;
   logic [4:0] last_idx;

   // Drive low for a given byte index and bit slot
   function automatic logic sda_low_f(input logic [31:0] cmd,
                                      input logic [4:0] idx,
                                      input logic [3:0] bitn);
      logic snd;
      logic [7:0] b;
      logic lst;
      snd = (idx == 5'h00) || !cmd[CMD_RW_BIT];
      // Address byte goes out as seven address bits, then R/W last
      b = (idx == 5'h00) ? {cmd[CMD_ADDR_LSB +: 7], cmd[CMD_RW_BIT]} :
          (idx == 5'h01 && !cmd[CMD_RW_BIT]) ?
          cmd[CMD_INSTR_LSB +: 8] : cmd[CMD_DATA_LSB +: 8];
      lst = (idx == ((cmd[CMD_RW_BIT] ? 5'h01 : 5'h02) +
                     5'(cmd[CMD_CNT_LSB +: 4])));
      if (bitn != BIT_ACK)
         sda_low_f = snd && !b[3'(BIT_LAST - bitn)];
      else
         sda_low_f = !snd && !lst;
   endfunction

   // ========================================================
   // Transfer sequencer
   always_comb
   begin
      st_d = st_q;
      cmd_d = cmd_q;
      bidx_d = bidx_q;
      bit_d = bit_q;
      rx_d = rx_q;
      nack_d = nack_q;
      scl_d = scl_q;
      sdal_d = sdal_q;
      tick = (tmr_q == 16'h0000);
      tmr_d = (st_q == HS_IDLE || tick) ? HALF_LOAD : tmr_q - 16'h0001;
      sending = (bidx_q == 5'h00) || !cmd_q[CMD_RW_BIT];
      // Read: address then n+1 data; write: address, instruction, n+1 data
      last_idx = (cmd_q[CMD_RW_BIT] ? 5'h01 : 5'h02) +
                 5'(cmd_q[CMD_CNT_LSB +: 4]);
      last = (bidx_q == last_idx);
      go = wb_cyc_i && wb_stb_i && wb_we_i && ack_q &&
           wb_adr_i == REG_CMD && st_q == HS_IDLE;
      if (go)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wb_sel_i[i])
               cmd_d[i*8 +: 8] = wb_dat_i[i*8 +: 8];
         end
         if (wb_sel_i[3] && wb_dat_i[CMD_GO_BIT])
         begin
            st_d = HS_START;
            sdal_d = 1'b1;
            nack_d = 1'b0;
            bidx_d = 5'h00;
            bit_d = 4'h0;
         end
      end
      case (st_q)
         HS_IDLE:
         begin
            scl_d = 1'b1;
         end
         HS_START:
         begin
            if (tick)
            begin
               st_d = HS_BLO;
               scl_d = 1'b0;
               sdal_d = sda_low_f(cmd_q, bidx_q, bit_q);
            end
         end
         HS_BLO:
         begin
            if (tick)
            begin
               st_d = HS_BHI;
               scl_d = 1'b1;
            end
         end
         HS_BHI:
         begin
            if (tick)
            begin
               scl_d = 1'b0;
               st_d = HS_BLO;
               if (bit_q != BIT_ACK)
               begin
                  if (!sending)
                     rx_d = {rx_q[6:0], bus.sda};
                  bit_d = bit_q + 4'h1;
                  sdal_d = sda_low_f(cmd_q, bidx_q, bit_q + 4'h1);
               end
               else if ((sending && bus.sda) || last)
               begin
                  nack_d = sending && bus.sda;
                  st_d = HS_STA;
                  sdal_d = 1'b1;
               end
               else
               begin
                  bidx_d = bidx_q + 5'h01;
                  bit_d = 4'h0;
                  sdal_d = sda_low_f(cmd_q, bidx_q + 5'h01, 4'h0);
               end
            end
         end
         HS_STA:
         begin
            if (tick)
            begin
               st_d = HS_STB;
               scl_d = 1'b1;
            end
         end
         HS_STB:
         begin
            if (tick)
            begin
               st_d = HS_STC;
               sdal_d = 1'b0;
            end
         end
         HS_STC:
         begin
            if (tick)
               st_d = HS_IDLE;
         end
         default:
         begin
            st_d = HS_IDLE;
         end
      endcase
   end

   // ========================================================
   // Wishbone slave, one wait state
   always_comb
   begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      rd_d = 32'h0000_0000;
      if (wb_adr_i == REG_CMD)
         rd_d = cmd_q;
      else if (wb_adr_i == REG_STAT)
      begin
         rd_d[STAT_BUSY_BIT] = (st_q != HS_IDLE);
         rd_d[STAT_NACK_BIT] = nack_q;
         rd_d[STAT_RDATA_LSB +: 8] = rx_q;
      end
      wb_ack_o = ack_q;
      wb_dat_o = rd_q;
      busy_o = (st_q != HS_IDLE);
      bus.m_scl_o = 1'b0;
      bus.m_scl_oe = !scl_q;
      bus.m_sda_o = 1'b0;
      bus.m_sda_oe = sdal_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= HS_IDLE;
         cmd_q <= CMD_RST;
         tmr_q <= 16'h0000;
         bidx_q <= 5'h00;
         bit_q <= 4'h0;
         rx_q <= 8'h00;
         nack_q <= 1'b0;
         scl_q <= 1'b1;
         sdal_q <= 1'b0;
         ack_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         cmd_q <= cmd_d;
         tmr_q <= tmr_d;
         bidx_q <= bidx_d;
         bit_q <= bit_d;
         rx_q <= rx_d;
         nack_q <= nack_d;
         scl_q <= scl_d;
         sdal_q <= sdal_d;
         ack_q <= ack_d;
         rd_q <= rd_d;
      end
   end
endmodule

/* tb/dps_assertions.sv */
// Protocol checks on the two-wire bus between controller and port
`timescale 1ns/100ps
module dps_assertions (
   input wire logic ref_clk_i, // System clock
   input wire logic rst_n_i,   // Async reset, active low
   input wire logic m_scl_o,   // Controller clock level
   input wire logic m_scl_oe,  // Controller pulls clock
   input wire logic m_sda_o,   // Controller data level
   input wire logic m_sda_oe,  // Controller pulls data
   input wire logic s_sda_o,   // Port data level
   input wire logic s_sda_oe,  // Port pulls data
   input wire logic scl,       // Wired clock line
   input wire logic sda        // Wired data line
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ==========================================================
   // Bus protocol
   reset_rel_a: assert property (
      !$past(rst_n_i) |-> !s_sda_oe && !m_sda_oe && !m_scl_oe)
      else $error("bus not released after reset");
   port_sda_low_a: assert property (
      $changed(s_sda_oe) |-> !scl && !$past(scl))
      else $error("port changed data while clock high");
   start_by_host_a: assert property (
      scl && $past(scl) && $fell(sda) |-> m_sda_oe && !s_sda_oe)
      else $error("start not made by controller");
   stop_release_a: assert property (
      scl && $past(scl) && $rose(sda) |=> !s_sda_oe [*8])
      else $error("port drives data after stop");
   ack_no_fight_a: assert property (
      s_sda_oe && scl |-> !m_sda_oe)
      else $error("both ends drive data");
   ack_hold_a: assert property (
      $rose(s_sda_oe) |-> s_sda_oe [*8])
      else $error("port drive too short");
   ack_pulse_a: assert property (
      $rose(s_sda_oe) |-> ##[1:24] (scl && s_sda_oe))
      else $error("port drive not held over clock pulse");
   host_sda_hold_a: assert property (
      $rose(scl) |=> $stable(m_sda_oe) [*2])
      else $error("controller changed data while clock high");
endmodule

/* tb/digipot_i2c_slave_port_tb.sv */
// Self-checking bench: controller and port joined over the two-wire bus
`timescale 1ns/100ps
module digipot_i2c_slave_port_tb;
   import dps_pkg::*;
   localparam logic [5:0] PFX = 6'h2a; // Arbitrary value
   localparam int HALF = 8;
   localparam int LIMIT = 40000;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat_w = 32'h0000_0000;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic busy;
   logic sel_pin = 1'b1;
   logic asel_pin = 1'b0;
   logic [7:0] wiper;
   logic a_open;
   logic b_short;
   logic addr_st;
   logic [7:0] d;
   logic [63:0] note;
   logic [63:0] exp_q[$];
   integer seed = 32'h2c3ed439;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;

   always #25 ref_clk_i = ~ref_clk_i;

   // ==========================================================
   // Design and checker
   dps_bus_if u_dps_bus_if ();
   dps_host #(.HALF_CYC(HALF)) u_dps_host (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
      .bus(u_dps_bus_if.master), .busy_o(busy));
   dps_dev #(.ADDR_PREFIX(PFX)) u_dps_dev (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .bus(u_dps_bus_if.slave), .interface_select_pin_i(sel_pin),
      .address_select_pin_i(asel_pin), .wiper_code_o(wiper),
      .terminal_a_open_o(a_open), .wiper_b_short_o(b_short),
      .addressed_o(addr_st));
   dps_assertions u_dps_assertions (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .m_scl_o(u_dps_bus_if.m_scl_o), .m_scl_oe(u_dps_bus_if.m_scl_oe),
      .m_sda_o(u_dps_bus_if.m_sda_o), .m_sda_oe(u_dps_bus_if.m_sda_oe),
      .s_sda_o(u_dps_bus_if.s_sda_o), .s_sda_oe(u_dps_bus_if.s_sda_oe),
      .scl(u_dps_bus_if.scl), .sda(u_dps_bus_if.sda));

   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat_w <= v;
      @(posedge ref_clk_i);
      while (wb_ack !== 1'b1)
         @(posedge ref_clk_i);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] v);
      exp_q.push_back({m, v});
      wb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic xfer(input logic rw, input logic as, input logic [7:0] ins,
                       input logic [7:0] v, input logic [3:0] n);
      wb(1'b1, REG_CMD, {1'b1, 3'h0, n, v, ins, rw, PFX, as});
      while (busy !== 1'b0)
         @(posedge ref_clk_i);
   endtask

   // ==========================================================
   // Read monitor and timeout
   always @(posedge ref_clk_i)
      if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         check(wb_dat_r & note[63:32], note[31:0]);
      end

   always @(posedge ref_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   // ==========================================================
   // Scenarios
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      check({24'h0, wiper}, {24'h0, WIPER_RST});
      check({30'h0, a_open, b_short}, 32'h0);
      check({31'h0, addr_st}, 32'h0);
      rd(REG_CMD, 32'hffff_ffff, CMD_RST);
      rd(REG_STAT, 32'hffff_ffff, 32'h0);
      wb(1'b1, 8'h08, 32'hffff_ffff);
      rd(8'h08, 32'hffff_ffff, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 2; i++)
      begin
         asel_pin <= i[0];
         d = 8'($random(seed));
         xfer(1'b0, i[0], 8'h00, d, 4'h1);
         check({24'h0, wiper}, {24'h0, d});
         rd(REG_STAT, 32'h0000_0003, 32'h0);
         xfer(1'b1, i[0], 8'h00, 8'h00, 4'h2);
         check({31'h0, addr_st}, 32'h0);
         rd(REG_STAT, 32'h0000_ff03, {16'h0, d, 8'h00});
         xfer(1'b0, !i[0], 8'h00, ~d, 4'h0);
         check({24'h0, wiper}, {24'h0, d});
         check({31'h0, addr_st}, 32'h0);
         rd(REG_STAT, 32'h0000_0002, 32'h0000_0002);
      end
      $display("test address done");
      sel_pin <= 1'b0;
      xfer(1'b0, 1'b1, 8'h00, ~d, 4'h0);
      check({24'h0, wiper}, {24'h0, d});
      rd(REG_STAT, 32'h0000_0002, 32'h0000_0002);
      sel_pin <= 1'b1;
      $display("test select done");
      d = 8'($random(seed));
      xfer(1'b0, 1'b1, 8'h20, d, 4'h0);
      check({30'h0, a_open, b_short}, 32'h3);
      check({24'h0, wiper}, {24'h0, d});
      xfer(1'b0, 1'b1, 8'h9f, ~d, 4'h0);
      check({30'h0, a_open, b_short}, 32'h0);
      check({24'h0, wiper}, {24'h0, ~d});
      $display("test shutdown done");
      xfer(1'b0, 1'b1, 8'h40, d, 4'h1);
      check({24'h0, wiper}, {24'h0, WIPER_MIDSCALE});
      xfer(1'b1, 1'b1, 8'h00, 8'h00, 4'h0);
      rd(REG_STAT, 32'h0000_ff03, {16'h0, 8'h80, 8'h00});
      $display("test midscale done");
      repeat (4)
      begin
         d = 8'($random(seed));
         xfer(1'b0, 1'b1, 8'($random(seed)) & 8'h9f, d, 4'h0);
         xfer(1'b1, 1'b1, 8'h00, 8'h00, 4'h0);
         rd(REG_STAT, 32'h0000_ff03, {16'h0, d, 8'h00});
      end
      $display("test random done");
      repeat (2) @(posedge ref_clk_i);
      finish_test();
   end
endmodule
